// >>> design/timer_compare_pkg.sv
package timer_compare_pkg;

    // ****************************************
    // bus geometry
    // ****************************************
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam int CHANNELS = 2;

    // ****************************************
    // register offsets (byte addresses)
    // ****************************************
    localparam logic [3:0] CONST_A_OFS = 4'h0;
    localparam logic [3:0] CONST_B_OFS = 4'h4;
    localparam logic [3:0] CTRL_CH0_OFS = 4'h8;
    localparam logic [3:0] CTRL_CH1_OFS = 4'hc;

    // ****************************************
    // reset values and field positions
    // ****************************************
    localparam logic [7:0] CONST_RESET = 8'hff;
    localparam logic [3:0] OUT_SEL_RESET = 4'h0;
    localparam int OUT_SEL_A_LO_POS = 0;
    localparam int OUT_SEL_A_HI_POS = 1;
    localparam int OUT_SEL_B_LO_POS = 2;
    localparam int OUT_SEL_B_HI_POS = 3;
    localparam int FLAG_A_POS = 6;
    localparam int FLAG_B_POS = 7;

    // ****************************************
    // output select encodings and bus answers
    // ****************************************
    localparam logic [1:0] OUT_KEEP = 2'h0;
    localparam logic [1:0] OUT_LOW = 2'h1;
    localparam logic [1:0] OUT_HIGH = 2'h2;
    localparam logic [1:0] OUT_TOGGLE = 2'h3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // one-hot register selection from an address
    typedef enum logic [4:0] {
        REG_NONE = 5'h01,
        REG_CONST_A = 5'h02,
        REG_CONST_B = 5'h04,
        REG_CTRL_CH0 = 5'h08,
        REG_CTRL_CH1 = 5'h10
    } reg_sel_t;

endpackage : timer_compare_pkg

// >>> design/compare_unit.sv
module compare_unit (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] channel_counter,
    input wire logic [7:0] match_const_a,
    input wire logic [7:0] match_const_b,
    input wire logic suppress_a,
    input wire logic suppress_b,
    output logic match_a,
    output logic match_b
);
    import timer_compare_pkg::*;

    typedef struct packed {
        logic eq_a_prev;
        logic eq_b_prev;
        logic match_a;
        logic match_b;
    } cmp_state_t;

    cmp_state_t st_reg;
    cmp_state_t st_next;
    logic eq_a;
    logic eq_b;

    // ****************************************
    // equality detection
    // ****************************************
    // raw equality every clock, before suppression
    always_comb begin
        eq_a = (channel_counter == match_const_a);
        eq_b = (channel_counter == match_const_b);
    end

    // one event per arrival at the constant; suppression does not re-arm
    always_comb begin
        st_next = st_reg;
        st_next.eq_a_prev = eq_a;
        st_next.eq_b_prev = eq_b;
        st_next.match_a = eq_a && !st_reg.eq_a_prev && !suppress_a;
        st_next.match_b = eq_b && !st_reg.eq_b_prev && !suppress_b;
    end

    // state register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign match_a = st_reg.match_a;
    assign match_b = st_reg.match_b;

    // ****************************************
    // assertions
    // ****************************************
    suppress_blank_a: assert property (
        @(posedge aclk) disable iff (!aresetn) suppress_a |=> !match_a)
        else $error("match a raised during a constant write");
    match_cause_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        match_a |-> $past(channel_counter == match_const_a))
        else $error("match a without equality");
    match_cause_b: assert property (
        @(posedge aclk) disable iff (!aresetn)
        match_b |-> $past(channel_counter == match_const_b))
        else $error("match b without equality");
    single_event_a: assert property (
        @(posedge aclk) disable iff (!aresetn) match_a |=> !match_a)
        else $error("match a lasted more than one cycle");

endmodule : compare_unit

// >>> design/timer_compare_constants.sv
//
// Function
// - each channel has an 8-bit read/write constant A register.
// - each channel has an 8-bit read/write constant B register.
// - both channels' same-letter constants form one 16-bit word location.
// - constant A compared with counter always; equality sets match flag A.
// - constant B compared with counter always; equality sets match flag B.
// - compare for a constant is blanked in the cycle it is written.
// - an A match drives the output pin as the low select bits say.
// - a B match without a same-cycle A match drives the output pin as the high select bits say.
// - reset loads all ones into both constant A registers.
// - reset loads all ones into both constant B registers.
//
module timer_compare_constants (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [timer_compare_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [timer_compare_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [timer_compare_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [timer_compare_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [7:0] channel_counter_0,
    input wire logic [7:0] channel_counter_1,
    output logic timer_output_pin_0,
    output logic timer_output_pin_1
);
    import timer_compare_pkg::*;

    typedef struct packed {
        logic [1:0][7:0] const_a;
        logic [1:0][7:0] const_b;
        logic [1:0][3:0] out_sel;
        logic [1:0] flag_a;
        logic [1:0] flag_b;
        logic [1:0] pin;
        logic aw_held;
        logic w_held;
        logic [ADDR_W-1:0] aw_addr;
        logic [DATA_W-1:0] w_data;
        logic [3:0] w_strb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [DATA_W-1:0] rdata;
    } state_t;

    localparam state_t STATE_RST = '{
        const_a: {CONST_RESET, CONST_RESET},
        const_b: {CONST_RESET, CONST_RESET},
        out_sel: {OUT_SEL_RESET, OUT_SEL_RESET},
        awready: 1'b1,
        wready: 1'b1,
        arready: 1'b1,
        default: '0
    };

    state_t st_reg;
    state_t st_next;
    logic wr_do;
    reg_sel_t wr_sel;
    reg_sel_t rd_sel;
    logic [1:0][7:0] counter;
    logic [1:0] suppress_a;
    logic [1:0] suppress_b;
    logic [1:0] match_a;
    logic [1:0] match_b;

    // ****************************************
    // helpers
    // ****************************************
    // address to one-hot register select, used by both read and write
    function automatic reg_sel_t decode(input logic [ADDR_W-1:0] addr);
        reg_sel_t sel;
        case (addr)
            CONST_A_OFS: sel = REG_CONST_A;
            CONST_B_OFS: sel = REG_CONST_B;
            CTRL_CH0_OFS: sel = REG_CTRL_CH0;
            CTRL_CH1_OFS: sel = REG_CTRL_CH1;
            default: sel = REG_NONE;
        endcase
        return sel;
    endfunction : decode

    // new pin level for one output select setting
    function automatic logic apply_sel(input logic [1:0] sel, input logic cur);
        logic lvl;
        case (sel)
            OUT_LOW: lvl = 1'b0;
            OUT_HIGH: lvl = 1'b1;
            OUT_TOGGLE: lvl = !cur;
            default: lvl = cur;
        endcase
        return lvl;
    endfunction : apply_sel

    // ****************************************
    // compare stages, one per channel
    // ****************************************
    assign counter[0] = channel_counter_0;
    assign counter[1] = channel_counter_1;

    // write commit cycle blanks the compare of the written constants
    always_comb begin
        wr_do = st_reg.aw_held && st_reg.w_held && !st_reg.bvalid;
        wr_sel = decode(st_reg.aw_addr);
        for (int c = 0; c < CHANNELS; c++) begin
            suppress_a[c] = wr_do && (wr_sel == REG_CONST_A) && st_reg.w_strb[c];
            suppress_b[c] = wr_do && (wr_sel == REG_CONST_B) && st_reg.w_strb[c];
        end
    end

    generate
        for (genvar g = 0; g < CHANNELS; g++) begin : g_cmp
            compare_unit u_cmp (
                .aclk(aclk),
                .aresetn(aresetn),
                .channel_counter(counter[g]),
                .match_const_a(st_reg.const_a[g]),
                .match_const_b(st_reg.const_b[g]),
                .suppress_a(suppress_a[g]),
                .suppress_b(suppress_b[g]),
                .match_a(match_a[g]),
                .match_b(match_b[g])
            );
        end
    endgenerate

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        st_next = st_reg;
        rd_sel = decode(s_axi_araddr);

        // write address and data taken independently
        if (s_axi_awvalid && st_reg.awready) begin
            st_next.aw_held = 1'b1;
            st_next.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st_reg.wready) begin
            st_next.w_held = 1'b1;
            st_next.w_data = s_axi_wdata;
            st_next.w_strb = s_axi_wstrb;
        end

        // register write commit
        if (wr_do) begin
            st_next.aw_held = 1'b0;
            st_next.w_held = 1'b0;
            st_next.bvalid = 1'b1;
            st_next.bresp = (wr_sel == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
            for (int c = 0; c < CHANNELS; c++) begin
                if (wr_sel == REG_CONST_A && st_reg.w_strb[c]) begin
                    st_next.const_a[c] = st_reg.w_data[8*c +: 8];
                end
                if (wr_sel == REG_CONST_B && st_reg.w_strb[c]) begin
                    st_next.const_b[c] = st_reg.w_data[8*c +: 8];
                end
            end
            if (wr_sel == REG_CTRL_CH0 && st_reg.w_strb[0]) begin
                st_next.out_sel[0] = st_reg.w_data[3:0];
                st_next.flag_a[0] = st_reg.flag_a[0] & st_reg.w_data[FLAG_A_POS];
                st_next.flag_b[0] = st_reg.flag_b[0] & st_reg.w_data[FLAG_B_POS];
            end
            if (wr_sel == REG_CTRL_CH1 && st_reg.w_strb[0]) begin
                st_next.out_sel[1] = st_reg.w_data[3:0];
                st_next.flag_a[1] = st_reg.flag_a[1] & st_reg.w_data[FLAG_A_POS];
                st_next.flag_b[1] = st_reg.flag_b[1] & st_reg.w_data[FLAG_B_POS];
            end
        end
        if (st_reg.bvalid && s_axi_bready) begin
            st_next.bvalid = 1'b0;
        end
        st_next.awready = !st_next.aw_held;
        st_next.wready = !st_next.w_held;

        // flags and output pins, set wins over a clearing write
        for (int c = 0; c < CHANNELS; c++) begin
            st_next.flag_a[c] = st_next.flag_a[c] | match_a[c];
            st_next.flag_b[c] = st_next.flag_b[c] | match_b[c];
            if (match_b[c]) begin
                st_next.pin[c] = apply_sel(st_reg.out_sel[c][OUT_SEL_B_HI_POS:OUT_SEL_B_LO_POS],
                    st_reg.pin[c]);
            end
            // a select drives pin, a wins
            if (match_a[c]) begin
                st_next.pin[c] = apply_sel(st_reg.out_sel[c][OUT_SEL_A_HI_POS:OUT_SEL_A_LO_POS],
                    st_reg.pin[c]);
            end
        end

        // read channel
        if (s_axi_arvalid && st_reg.arready) begin
            st_next.arready = 1'b0;
            st_next.rvalid = 1'b1;
            st_next.rresp = RESP_OKAY;
            case (rd_sel)
                REG_CONST_A: st_next.rdata = {16'h0000, st_reg.const_a[1], st_reg.const_a[0]};
                REG_CONST_B: st_next.rdata = {16'h0000, st_reg.const_b[1], st_reg.const_b[0]};
                REG_CTRL_CH0: st_next.rdata = {24'h000000, st_reg.flag_b[0], st_reg.flag_a[0],
                    2'h0, st_reg.out_sel[0]};
                REG_CTRL_CH1: st_next.rdata = {24'h000000, st_reg.flag_b[1], st_reg.flag_a[1],
                    2'h0, st_reg.out_sel[1]};
                default: begin
                    st_next.rdata = 32'h00000000;
                    st_next.rresp = RESP_SLVERR;
                end
            endcase
        end else if (st_reg.rvalid && s_axi_rready) begin
            st_next.rvalid = 1'b0;
            st_next.arready = 1'b1;
        end
    end

    // ****************************************
    // state register
    // ****************************************
    // constants reset to all ones
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg <= STATE_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs straight from the state register
    assign s_axi_awready = st_reg.awready;
    assign s_axi_wready = st_reg.wready;
    assign s_axi_bvalid = st_reg.bvalid;
    assign s_axi_bresp = st_reg.bresp;
    assign s_axi_arready = st_reg.arready;
    assign s_axi_rvalid = st_reg.rvalid;
    assign s_axi_rresp = st_reg.rresp;
    assign s_axi_rdata = st_reg.rdata;
    assign timer_output_pin_0 = st_reg.pin[0];
    assign timer_output_pin_1 = st_reg.pin[1];

    // ****************************************
    // assertions
    // ****************************************
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    const_a_write_a: assert property (
        wr_do && wr_sel == REG_CONST_A && st_reg.w_strb[0]
        |=> st_reg.const_a[0] == $past(st_reg.w_data[7:0]))
        else $error("constant a channel 0 not written");
    const_b_write_a: assert property (
        wr_do && wr_sel == REG_CONST_B && st_reg.w_strb[1]
        |=> st_reg.const_b[1] == $past(st_reg.w_data[15:8]))
        else $error("constant b channel 1 not written");
    word_pair_a: assert property (
        wr_do && wr_sel == REG_CONST_A && st_reg.w_strb[1:0] == 2'h3
        |=> st_reg.const_a == $past(st_reg.w_data[15:0]))
        else $error("16-bit constant a word not written whole");
    flag_set_a: assert property (
        match_a[0] |=> st_reg.flag_a[0])
        else $error("match flag a not set on match");
    flag_set_b: assert property (
        match_b[1] |=> st_reg.flag_b[1])
        else $error("match flag b not set on match");
    pin_low_a: assert property (
        match_a[0] && st_reg.out_sel[0][1:0] == OUT_LOW |=> !timer_output_pin_0)
        else $error("pin not driven low on a match");
    pin_toggle_b: assert property (
        match_b[0] && !match_a[0] && st_reg.out_sel[0][3:2] == OUT_TOGGLE
        |=> timer_output_pin_0 != $past(timer_output_pin_0))
        else $error("pin not toggled on b match");
    reset_const_a: assert property (disable iff (1'b0)
        !aresetn |=> st_reg.const_a == {CONST_RESET, CONST_RESET})
        else $error("constant a not all ones after reset");
    reset_const_b: assert property (disable iff (1'b0)
        !aresetn |=> st_reg.const_b == {CONST_RESET, CONST_RESET})
        else $error("constant b not all ones after reset");
    flag_sticky_a: assert property (
        st_reg.flag_a[1] && !(wr_do && wr_sel == REG_CTRL_CH1 && st_reg.w_strb[0])
        |=> st_reg.flag_a[1])
        else $error("match flag a dropped without a clear");
    const_a_lane1_a: assert property (
        wr_do && wr_sel == REG_CONST_A && st_reg.w_strb[1]
        |=> st_reg.const_a[1] == $past(st_reg.w_data[15:8]))
        else $error("constant a channel 1 not written");
    const_b_lane0_a: assert property (
        wr_do && wr_sel == REG_CONST_B && st_reg.w_strb[0]
        |=> st_reg.const_b[0] == $past(st_reg.w_data[7:0]))
        else $error("constant b channel 0 not written");
    word_pair_b_a: assert property (
        wr_do && wr_sel == REG_CONST_B && st_reg.w_strb[1:0] == 2'h3
        |=> st_reg.const_b == $past(st_reg.w_data[15:0]))
        else $error("16-bit constant b word not written whole");
    flag_a_ch1_a: assert property (
        match_a[1] |=> st_reg.flag_a[1])
        else $error("match flag a channel 1 not set on match");
    flag_b_ch0_a: assert property (
        match_b[0] |=> st_reg.flag_b[0])
        else $error("match flag b channel 0 not set on match");
    blank_b_ch1_a: assert property (
        suppress_b[1] |=> !match_b[1])
        else $error("match b raised during a constant write");
    pin_high_a: assert property (
        match_a[1] && st_reg.out_sel[1][1:0] == OUT_HIGH |=> timer_output_pin_1)
        else $error("pin not driven high on an a match");
    pin_low_b_a: assert property (
        match_b[1] && !match_a[1] && st_reg.out_sel[1][3:2] == OUT_LOW
        |=> !timer_output_pin_1)
        else $error("pin not driven low on a b match");
    pin_quiet_a: assert property (
        !match_a[0] && !match_b[0]
        |=> timer_output_pin_0 == $past(timer_output_pin_0))
        else $error("pin moved without a match");
    flag_sticky_b: assert property (
        st_reg.flag_b[0] && !(wr_do && wr_sel == REG_CTRL_CH0 && st_reg.w_strb[0])
        |=> st_reg.flag_b[0])
        else $error("match flag b dropped without a clear");

endmodule : timer_compare_constants

// >>> verification/timer_compare_constants_tb.sv
module timer_compare_constants_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import timer_compare_pkg::*;

    // ****************************************
    // signals and bench state
    // ****************************************
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, pin_0, pin_1;
    logic [3:0] awaddr, araddr, wstrb;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    logic [7:0] cnt_0, cnt_1;
    int fail_count, num_checks, seed, i;
    logic [7:0] cst [2][2];
    logic pm [2];

    timer_compare_constants i_timer_compare_constants (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .channel_counter_0(cnt_0), .channel_counter_1(cnt_1),
        .timer_output_pin_0(pin_0), .timer_output_pin_1(pin_1)
    );

    // free-running clock, 4 ns period
    always #2 aclk = ~aclk;

    // ****************************************
    // reporting
    // ****************************************
    task automatic finish_test();
        $display("checks %0d errors %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : finish_test

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // bounded wait ran out: count it and stop
    task automatic hang(input int n);
        if (n >= 100) begin
            check(32'h0, 32'h1);
            finish_test();
        end
    endtask : hang

    // answer code for an address: error for anything off the register map
    function automatic logic [1:0] exp_resp(input logic [3:0] a);
        if (a == CONST_A_OFS || a == CONST_B_OFS || a == CTRL_CH0_OFS || a == CTRL_CH1_OFS) begin
            return RESP_OKAY;
        end
        return RESP_SLVERR;
    endfunction : exp_resp

    // ****************************************
    // bus master tasks
    // ****************************************
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        logic aw_done, w_done;
        n = 0;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (n < 100) begin
            @(posedge aclk);
            n++;
            if (aw_done && w_done && bvalid) break;
            if (!aw_done && awready) begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_done && wready) begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
        end
        hang(n);
        bready <= 1'b0;
        check({30'h0, bresp}, {30'h0, exp_resp(a)});
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        int n;
        logic a_done;
        n = 0;
        a_done = 1'b0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (n < 100) begin
            @(posedge aclk);
            n++;
            if (a_done && rvalid) break;
            if (!a_done && arready) begin
                a_done = 1'b1;
                arvalid <= 1'b0;
            end
        end
        hang(n);
        d = rdata;
        rready <= 1'b0;
        check({30'h0, rresp}, {30'h0, exp_resp(a)});
    endtask : rd

    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp, input logic [31:0] m);
        logic [31:0] got;
        rd(a, got);
        check(got & m, exp);
    endtask : rd_chk

    // constant write, mirrored in the bench copy
    task automatic wr_const(input int l, input logic [31:0] d, input logic [3:0] s);
        for (int c = 0; c < 2; c++) begin
            if (s[c]) cst[l][c] = d[8*c +: 8];
        end
        wr(l ? CONST_B_OFS : CONST_A_OFS, d, s);
    endtask : wr_const

    task automatic set_cnt(input int ch, input logic [7:0] v, input int w);
        @(posedge aclk);
        if (ch == 1) cnt_1 <= v;
        else cnt_0 <= v;
        repeat (w) @(posedge aclk);
    endtask : set_cnt

    function automatic logic exp_pin(input logic [1:0] m, input logic p);
        case (m)
            OUT_KEEP: return p;
            OUT_LOW: return 1'b0;
            OUT_HIGH: return 1'b1;
            default: return ~p;
        endcase
    endfunction : exp_pin

    // ****************************************
    // two compare events per channel, letter and mode
    // ****************************************
    task automatic match_case(input int ch, input int l, input logic [1:0] m);
        logic [7:0] v, sel, fm;
        logic [3:0] ca;
        v = 8'($random(seed));
        if (v == cst[1-l][ch]) v = ~v;
        sel = {6'h0, m} << (2 * l);
        fm = 8'h40 << l;
        ca = ch ? CTRL_CH1_OFS : CTRL_CH0_OFS;
        wr(ca, 32'h0, 4'h1);
        wr_const(l, {16'h0, v, v}, 4'h1 << ch);
        set_cnt(ch, ~v, 4);
        wr(ca, {24'h0, sel}, 4'h1);
        set_cnt(ch, v, 4);
        pm[ch] = exp_pin(m, pm[ch]);
        check({31'h0, ch ? pin_1 : pin_0}, {31'h0, pm[ch]});
        rd_chk(ca, {24'h0, fm | sel}, {24'h0, fm | 8'h0f});
        set_cnt(ch, ~v, 4);
        rd_chk(ca, {24'h0, fm}, {24'h0, fm});
        set_cnt(ch, v, 4);
        pm[ch] = exp_pin(m, pm[ch]);
        check({31'h0, ch ? pin_1 : pin_0}, {31'h0, pm[ch]});
        rd_chk(ca, {24'h0, fm}, {24'h0, fm});
        wr(ca, {24'h0, sel}, 4'h1);
        repeat (4) @(posedge aclk);
        rd_chk(ca, 32'h0, {24'h0, fm});
        check({31'h0, ch ? pin_1 : pin_0}, {31'h0, pm[ch]});
    endtask : match_case

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        aclk = 1'b0;
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wstrb, wdata, cnt_0, cnt_1} = '0;
        fail_count = 0;
        num_checks = 0;
        seed = 42518;
        cst = '{'{8'hff, 8'hff}, '{8'hff, 8'hff}};
        pm = '{1'b0, 1'b0};
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        // reset contents of the constants and control words
        rd_chk(CONST_A_OFS, 32'h0000ffff, 32'hffffffff);
        rd_chk(CONST_B_OFS, 32'h0000ffff, 32'hffffffff);
        rd_chk(CTRL_CH0_OFS, 32'h0, 32'hffffffff);
        rd_chk(CTRL_CH1_OFS, 32'h0, 32'hffffffff);
        // random byte and word writes, read back as one word
        for (i = 0; i < 16; i++) begin
            wr_const(i % 2, $random(seed), {2'($random(seed)), 2'(1 + i % 3)});
            rd_chk(i % 2 ? CONST_B_OFS : CONST_A_OFS, {16'h0, cst[i%2][1], cst[i%2][0]},
                   32'hffffffff);
        end
        // unmapped word: error answer, zero data, constant A untouched
        wr(4'h2, $random(seed), 4'hf);
        rd_chk(4'h2, 32'h0, 32'hffffffff);
        rd_chk(CONST_A_OFS, {16'h0, cst[0][1], cst[0][0]}, 32'hffffffff);
        // every output mode on both letters and both channels
        for (i = 0; i < 16; i++) begin
            match_case(i % 2, (i / 2) % 2, 2'(i / 4));
        end
        // second reset mid-run: everything back to rest, counters off the constants
        @(posedge aclk);
        aresetn <= 1'b0;
        cnt_0 <= 8'h00;
        cnt_1 <= 8'h00;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rd_chk(CONST_A_OFS, 32'h0000ffff, 32'hffffffff);
        rd_chk(CONST_B_OFS, 32'h0000ffff, 32'hffffffff);
        rd_chk(CTRL_CH0_OFS, 32'h0, 32'hffffffff);
        rd_chk(CTRL_CH1_OFS, 32'h0, 32'hffffffff);
        check({30'h0, pin_1, pin_0}, 32'h0);
        finish_test();
    end

endmodule : timer_compare_constants_tb
